/* File: hw/ssq_pkg.sv */
// Shared constants, types and helpers for the sampling sequencer.
// Assumes a single 100 MHz system clock and synchronous pin inputs.
package ssq_pkg;

    // ********************************************************
    // Clock and conversion timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS  = 3000;
    // Least time per channel, rounded up to whole cycles
    localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    // ********************************************************
    // Widths, slots and mode word layout
    // ********************************************************
    localparam int RESULT_W      = 14;
    localparam int SLOTS         = 4;
    localparam int SLOT_W        = 2;
    localparam int MODE_W        = 4;
    localparam int MODE_PD_BIT   = 3;
    localparam int MODE_BANK_BIT = 2;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 2'h0;
    localparam logic [SLOTS-1:0]  HOLD_ALL   = 4'hF;
    localparam logic [SLOTS-1:0]  HOLD_NONE  = 4'h0;

    // Mode word as written over the low bus lines
    typedef struct packed {
        logic              pwr_down;
        logic              bank_b;
        logic [SLOT_W-1:0] count_m1;
    } ssq_mode_s;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } ssq_state_e;

    // Rising edge between a registered and a current level
    function automatic logic ssq_rise(input logic prev, input logic cur);
        return !prev && cur;
    endfunction

    // Falling edge between a registered and a current level
    function automatic logic ssq_fall(input logic prev, input logic cur);
        return prev && !cur;
    endfunction

endpackage

/* File: hw/ssq_result_mem.sv */
// Four-slot result memory with a registered read port.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ns
module ssq_result_mem import ssq_pkg::*; #(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = SLOTS,
    parameter int AW    = SLOT_W
) (
    input  wire logic             sys_clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    // ********************************************************
    // Storage
    // ********************************************************
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Write port and registered read port; contents undefined at power-up
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
        rd_data <= mem_r[rd_addr];
    end

endmodule

/* File: hw/ssq_chan_timer.sv */
// Per-channel conversion timer: pulses once per conversion slot.
// Assumes run stays high for the whole conversion sequence.
`timescale 1ns/1ns
module ssq_chan_timer import ssq_pkg::*; #(
    parameter int CYCLES = CONV_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);

    // ********************************************************
    // Cycle counter
    // ********************************************************
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;

    // End of slot and next count
    assign tick      = run && (count_r == LAST);
    assign count_nxt = (!run || tick) ? '0 : count_r + CW'(1);

    // Counter register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

/* File: hw/ssq_sequencer.sv */
// Sampling sequencer top: mode word, track/hold control, conversion
// sequencing, result memory and sequential read-out over a shared bus.
// Assumes all pins are synchronous to sys_clk; the analog converter
// presents adc_result for conv_chan by the end of each slot.
`timescale 1ns/1ns

// Functional notes
// - Trigger rise holds all stages, starts sequence
// - Triggers ignored while a sequence runs
// - Each channel takes 3 us, result stored
// - End lowers done flag, stages track again
// - Reads fixed order from first slot, wrap
// - Chip select high ignores strobes, bus off
// - Reset mode is bank A, one channel
// - Mode captured on write or select rise
// - Last written mode used for all triggers
// - Bit2 bank, bits1:0 channel count minus one
// - Bit3 set selects power-down
// - Done falls only after last programmed channel
// - First read fall drives data, raises done
// - Read rise advances result pointer
// - Pointer wraps after n read pulses
// - Select may stay low across many reads
// - Mode lines share low bus, driven on reads
// - Bit3 clear write wakes from power-down
// - Results twos complement, MSB on top line
module ssq_sequencer import ssq_pkg::*; #(
    parameter int CONV_CYCLES = CONV_CYC
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                sample_trigger_n,
    input  wire logic                cs_n,
    input  wire logic                wr_n,
    input  wire logic                rd_n,
    input  wire logic [RESULT_W-1:0] result_bus_in,
    output logic      [RESULT_W-1:0] result_bus_out,
    output logic                     result_bus_oe,
    output logic                     done_n,
    output logic      [SLOTS-1:0]    hold_ctrl,
    output logic                     bank_b_sel,
    output logic                     power_down,
    output logic                     conv_busy,
    output logic      [SLOT_W-1:0]   conv_chan,
    input  wire logic [RESULT_W-1:0] adc_result
);

    // ********************************************************
    // Pin history
    // ********************************************************
    logic              trig_prev_r;
    logic              cs_prev_r;
    logic              wr_prev_r;
    logic              rd_prev_r;
    logic [MODE_W-1:0] bus_lo_prev_r;

    // Previous levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trig_prev_r   <= 1'b1;
            cs_prev_r     <= 1'b1;
            wr_prev_r     <= 1'b1;
            rd_prev_r     <= 1'b1;
            bus_lo_prev_r <= MODE_RESET;
        end else begin
            trig_prev_r   <= sample_trigger_n;
            cs_prev_r     <= cs_n;
            wr_prev_r     <= wr_n;
            rd_prev_r     <= rd_n;
            bus_lo_prev_r <= result_bus_in[MODE_W-1:0];
        end
    end

    // ********************************************************
    // Strobe decode
    // ********************************************************
    logic trig_rise;
    logic wr_cap;
    logic rd_fall;
    logic rd_rise;
    logic pd_write;

    // Edges; strobes only count while selected
    assign trig_rise = ssq_rise(trig_prev_r, sample_trigger_n);
    assign wr_cap    = !wr_prev_r && !cs_prev_r && (wr_n || cs_n);
    assign rd_fall   = !cs_n && ssq_fall(rd_prev_r, rd_n);
    assign rd_rise   = !cs_n && ssq_rise(rd_prev_r, rd_n);
    assign pd_write  = wr_cap && bus_lo_prev_r[MODE_PD_BIT];

    // ********************************************************
    // Mode word
    // ********************************************************
    ssq_mode_s mode_r;
    ssq_mode_s mode_nxt;

    // New word replaces the old only on a capture edge
    assign mode_nxt = wr_cap ? ssq_mode_s'(bus_lo_prev_r) : mode_r;

    // Mode register; wake-up is any captured word with bit 3 clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_r <= ssq_mode_s'(MODE_RESET);
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ********************************************************
    // Sequencer decode
    // ********************************************************
    ssq_state_e        state_r;
    ssq_state_e        state_nxt;
    logic [SLOT_W-1:0] chan_r;
    logic [SLOT_W-1:0] chan_nxt;
    logic [SLOT_W-1:0] seq_cnt_r;
    logic [SLOT_W-1:0] seq_cnt_nxt;
    logic [SLOT_W-1:0] ptr_r;
    logic [SLOT_W-1:0] ptr_nxt;
    logic [SLOTS-1:0]  hold_r;
    logic [SLOTS-1:0]  hold_nxt;
    logic              done_n_r;
    logic              done_n_nxt;
    logic              bank_r;
    logic              bank_nxt;
    logic              in_conv;
    logic              chan_tick;
    logic              last_chan;
    logic              start_seq;
    logic              end_seq;
    logic              abort_seq;
    logic              mem_wr;
    logic [RESULT_W-1:0] mem_q;

    // Sequence start, slot end, last slot and abort
    assign in_conv   = (state_r == ST_CONV);
    assign start_seq = trig_rise && !in_conv && !mode_r.pwr_down;
    assign last_chan = (chan_r == seq_cnt_r);
    assign end_seq   = in_conv && chan_tick && last_chan && !pd_write;
    assign abort_seq = in_conv && pd_write;
    assign mem_wr    = in_conv && chan_tick && !pd_write;

    // Next state and slot; channel count fixed for the whole sample
    assign state_nxt   = start_seq ? ST_CONV :
                         (end_seq || abort_seq) ? ST_IDLE : state_r;
    assign seq_cnt_nxt = start_seq ? mode_r.count_m1 : seq_cnt_r;
    assign chan_nxt    = start_seq ? FIRST_SLOT :
                         (mem_wr && !last_chan) ? chan_r + SLOT_W'(1)
                                                : chan_r;

    // Track/hold control: hold on start, track at end or abort
    assign hold_nxt = start_seq ? HOLD_ALL :
                      (end_seq || abort_seq) ? HOLD_NONE : hold_r;

    // Done flag: set wins, so an end beats a clearing read
    assign done_n_nxt = end_seq ? 1'b0 :
                        (rd_fall || start_seq) ? 1'b1 : done_n_r;

    // Read pointer: first slot on start, advance and wrap on read rise
    assign ptr_nxt = start_seq ? FIRST_SLOT :
                     !rd_rise ? ptr_r :
                     (ptr_r == seq_cnt_r) ? FIRST_SLOT
                                          : ptr_r + SLOT_W'(1);

    // Bank follows mode between samples, frozen during a sequence
    assign bank_nxt = (state_nxt == ST_IDLE) ? mode_nxt.bank_b : bank_r;

    // ********************************************************
    // Sequencer registers
    // ********************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            chan_r    <= FIRST_SLOT;
            seq_cnt_r <= MODE_RESET[SLOT_W-1:0];
            ptr_r     <= FIRST_SLOT;
            hold_r    <= HOLD_NONE;
            done_n_r  <= 1'b1;
            bank_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            chan_r    <= chan_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            ptr_r     <= ptr_nxt;
            hold_r    <= hold_nxt;
            done_n_r  <= done_n_nxt;
            bank_r    <= bank_nxt;
        end
    end

    // ********************************************************
    // Slot timer and result memory
    // ********************************************************
    // Slot length in cycles derived from the clock rate
    ssq_chan_timer #(
        .CYCLES (CONV_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (in_conv),
        .tick    (chan_tick)
    );

    // One slot per channel, read in pointer order
    ssq_result_mem #(
        .WIDTH (RESULT_W),
        .DEPTH (SLOTS),
        .AW    (SLOT_W)
    ) u_mem (
        .sys_clk (sys_clk),
        .wr_en   (mem_wr),
        .wr_addr (chan_r),
        .wr_data (adc_result),
        .rd_addr (ptr_r),
        .rd_data (mem_q)
    );

    // ********************************************************
    // Bus and status outputs
    // ********************************************************
    logic [RESULT_W-1:0] bus_out_r;
    logic                bus_oe_r;
    logic                pwr_down_r;
    logic                busy_r;

    // Drive only while selected and reading; memory word passes unchanged
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_out_r  <= '0;
            bus_oe_r   <= 1'b0;
            pwr_down_r <= 1'b0;
            busy_r     <= 1'b0;
        end else begin
            bus_out_r  <= mem_q;
            bus_oe_r   <= !cs_n && !rd_n;
            pwr_down_r <= mode_nxt.pwr_down;
            busy_r     <= (state_nxt == ST_CONV);
        end
    end

    assign result_bus_out = bus_out_r;
    assign result_bus_oe  = bus_oe_r;
    assign done_n         = done_n_r;
    assign hold_ctrl      = hold_r;
    assign bank_b_sel     = bank_r;
    assign power_down     = pwr_down_r;
    assign conv_busy      = busy_r;
    assign conv_chan      = chan_r;

    // ********************************************************
    // Assertions
    // ********************************************************
    logic [11:0] seq_cyc_r;

    // Cycles spent converting in the current sequence
    always_ff @(posedge sys_clk) begin
        if (rst || start_seq) begin
            seq_cyc_r <= 12'h000;
        end else if (in_conv) begin
            seq_cyc_r <= seq_cyc_r + 12'h001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_start;
        trig_rise && !in_conv && !mode_r.pwr_down;
    endsequence

    sequence s_holding;
        hold_r == HOLD_ALL && state_r == ST_CONV && done_n_r;
    endsequence

    a_trigger_holds: assert property (s_start |=> s_holding)
        else $error("trigger did not hold all stages");

    a_busy_ignores: assert property (
        (in_conv && !chan_tick && !pd_write) |=>
            (in_conv && $stable(chan_r) && $stable(seq_cnt_r)))
        else $error("sequence disturbed mid slot");

    a_seq_length: assert property (
        end_seq |->
            (int'(seq_cyc_r) == (int'(seq_cnt_r) + 1) * CONV_CYCLES - 1))
        else $error("sequence length wrong");

    a_done_falls: assert property (end_seq |=>
        (!done_n_r && hold_r == HOLD_NONE && !in_conv))
        else $error("done flag or track not at end");

    a_done_last: assert property (
        (in_conv && !last_chan) |=> done_n_r)
        else $error("done flag fell before last channel");

    a_cs_quiet: assert property (cs_n |=> !result_bus_oe)
        else $error("bus driven while deselected");

    a_mode_capture: assert property (
        wr_cap |=> (mode_r == ssq_mode_s'($past(bus_lo_prev_r))))
        else $error("mode word not captured");

    a_read_done: assert property (
        (rd_fall && !end_seq) |=> (done_n_r && result_bus_oe))
        else $error("read did not raise done");

    a_ptr_adv: assert property (
        (rd_rise && !start_seq && ptr_r != seq_cnt_r) |=>
            (ptr_r == $past(ptr_r) + SLOT_W'(1)))
        else $error("pointer not advanced");

    a_ptr_wrap: assert property (
        (rd_rise && !start_seq && ptr_r == seq_cnt_r) |=> ptr_r == FIRST_SLOT)
        else $error("pointer did not wrap");

    a_pd_abort: assert property (
        (abort_seq && !rd_rise) |=>
            (!in_conv && $stable(ptr_r) && power_down && hold_r == HOLD_NONE))
        else $error("power-down write did not abort cleanly");

endmodule

/* File: verification/ssq_host.sv */
// Host model for the sampling sequencer: select, strobes, trigger, bus.
// Assumes the bench resolves the shared bus from the device output enable alone.
`timescale 1ns/1ns
module ssq_host import ssq_pkg::*; (
    input  wire logic                sys_clk,
    input  wire logic                dev_oe,
    output logic                     cs_n,
    output logic                     wr_n,
    output logic                     rd_n,
    output logic                     sample_trigger_n,
    output logic      [RESULT_W-1:0] drv_data,
    output logic                     drv_oe,
    input  wire logic [RESULT_W-1:0] bus
);
    // ********
    // Pin idle levels
    // ********
    initial begin
        cs_n             = 1'b1;
        wr_n             = 1'b1;
        rd_n             = 1'b1;
        sample_trigger_n = 1'b1;
        drv_data         = 14'h0000;
        drv_oe           = 1'b0;
    end

    // One clock, then the fixed drive offset
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask

    // Mode write, released by write strobe or by select
    task automatic write_mode(input logic [3:0] m, input logic via_cs);
        step;
        cs_n     = 1'b0;
        wr_n     = 1'b0;
        drv_oe   = 1'b1;
        drv_data = {10'h000, m};
        step;
        if (via_cs) cs_n = 1'b1;
        else wr_n = 1'b1;
        step;
        cs_n     = 1'b1;
        wr_n     = 1'b1;
        drv_oe   = 1'b0;
        drv_data = ~drv_data;
        step;
    endtask

    // One read pulse; select may stay low for the next one
    task automatic read_word(output logic [RESULT_W-1:0] d,
                             input logic keep_cs);
        step;
        cs_n = 1'b0;
        rd_n = 1'b0;
        step;
        step;
        d    = bus;
        rd_n = 1'b1;
        step;
        if (!keep_cs) cs_n = 1'b1;
        step;
    endtask

    // Strobes with select high; reports whether the device drove
    task automatic strobe_unselected(output logic seen_oe);
        step;
        rd_n     = 1'b0;
        wr_n     = 1'b0;
        drv_oe   = 1'b1;
        drv_data = 14'h0000;
        step;
        step;
        seen_oe  = dev_oe;
        rd_n     = 1'b1;
        wr_n     = 1'b1;
        drv_oe   = 1'b0;
        drv_data = ~drv_data;
        step;
    endtask

    // Low pulse on the trigger, rise is the event
    task automatic pulse_trigger;
        step;
        sample_trigger_n = 1'b0;
        step;
        sample_trigger_n = 1'b1;
    endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the sampling sequencer top.
// Assumes the host model drives pins; the converter is modelled here.
`timescale 1ns/1ns
module tb import ssq_pkg::*;;
    localparam int CYC = 4;
    localparam int TRACK_CYC = 100; // 1 us of tracking at 10 ns
    logic                sys_clk, rst, cs_n, wr_n, rd_n, trig_n;
    logic                drv_oe, bus_oe, done_n, bank_b_sel;
    logic                power_down, conv_busy, seen;
    logic [RESULT_W-1:0] drv_data, bus_out, adc_result, d;
    logic [SLOTS-1:0]    hold_ctrl;
    logic [SLOT_W-1:0]   conv_chan;
    logic [3:0]          seq;
    logic [3:0]          mv;
    wire  [RESULT_W-1:0] bus;
    int                  fails, n_compared;

    // ********
    // Clock, bus wire and converter model
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    assign bus        = bus_oe ? bus_out : drv_data;
    assign adc_result = {seq, bank_b_sel, conv_chan, 7'h55};

    ssq_sequencer #(.CONV_CYCLES(CYC)) dut (
        .sys_clk(sys_clk), .rst(rst), .sample_trigger_n(trig_n),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .result_bus_in(bus),
        .result_bus_out(bus_out), .result_bus_oe(bus_oe),
        .done_n(done_n), .hold_ctrl(hold_ctrl), .bank_b_sel(bank_b_sel),
        .power_down(power_down), .conv_busy(conv_busy),
        .conv_chan(conv_chan), .adc_result(adc_result));

    ssq_host host (
        .sys_clk(sys_clk), .dev_oe(bus_oe), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .sample_trigger_n(trig_n), .drv_data(drv_data),
        .drv_oe(drv_oe), .bus(bus));

    // ********
    // Checking and reporting
    // ********
    function automatic logic [13:0] word(input logic b,
                                         input logic [1:0] k);
        return {seq, b, k, 7'h55};
    endfunction

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Host and device never drive the shared bus together
    always @(negedge sys_clk) begin
        if (bus_oe === 1'b1 && drv_oe === 1'b1) begin
            check("bus contention", 16'h0000, 16'h0001);
        end
    end

    // Trigger, retrigger mid-run, time the run, read n+1 words
    task automatic run_seq(input int n, input logic b);
        int cnt;
        int k;
        int j;
        logic [RESULT_W-1:0] w;
        cnt = 0;
        k   = 0;
        seq = seq + 4'h1;
        repeat (TRACK_CYC) @(posedge sys_clk);
        host.pulse_trigger();
        fork
            while (k < 200 && !(cnt > 0 && done_n === 1'b0)) begin
                @(posedge sys_clk);
                #2;
                k++;
                if (conv_busy === 1'b1) cnt++;
                if (cnt == 1 && conv_busy === 1'b1)
                    check("hold", 16'h000F, 16'(hold_ctrl));
            end
            host.pulse_trigger();
        join
        if (k >= 200) begin
            fails++;
            final_report();
        end
        check("busy cycles", 16'(n * CYC), 16'(cnt));
        check("hold end", 16'h0000, 16'(hold_ctrl));
        check("bank", 16'(b), 16'(bank_b_sel));
        for (j = 0; j <= n; j++) begin
            host.read_word(d, j < n);
            w = word(b, 2'(j % n));
            check("word", 16'(w), 16'(d));
            if (j == 0) check("done", 16'h0001, 16'(done_n));
        end
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        fails      = 0;
        n_compared = 0;
        seq        = 4'h0;
        rst        = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check("reset state", 16'h0001, 16'({hold_ctrl, bank_b_sel,
              power_down, conv_busy, bus_oe, done_n}));
        run_seq(1, 1'b0);
        for (int m = 0; m < 8; m++) begin
            mv = 4'(m);
            host.write_mode(mv, mv[0]);
            check("power", 16'h0000, 16'(power_down));
            run_seq(int'(mv[1:0]) + 1, mv[2]);
        end
        run_seq(4, 1'b1);
        host.strobe_unselected(seen);
        check("oe unselected", 16'h0000, 16'(seen));
        check("bank unselected", 16'h0001, 16'(bank_b_sel));
        host.read_word(d, 1'b0);
        check("word unselected", 16'(word(1'b1, 2'h1)), 16'(d));
        host.write_mode(4'hC, 1'b0);
        check("power down", 16'h0001, 16'(power_down));
        host.pulse_trigger();
        repeat (3) @(posedge sys_clk);
        #1;
        check("busy down", 16'h0000, 16'(conv_busy));
        host.write_mode(4'h1, 1'b0);
        check("wake", 16'h0000, 16'({power_down, bank_b_sel}));
        run_seq(2, 1'b0);
        host.write_mode(4'h3, 1'b0);
        seq = seq + 4'h1;
        host.pulse_trigger();
        repeat (6) @(posedge sys_clk);
        host.write_mode(4'h8, 1'b1);
        check("abort", 16'h0003, 16'({hold_ctrl, conv_busy,
              power_down, done_n}));
        host.write_mode(4'h3, 1'b0);
        host.read_word(d, 1'b0);
        check("word kept", 16'(word(1'b0, 2'h0)), 16'(d));
        final_report();
    end
endmodule
